// File: src/mcr_pkg.sv
// Shared constants and types for the supply-line command frame receiver.
package mcr_pkg;
	// Clock rate and bit-rate window of the incoming link.
	localparam int CLK_KHZ = 20000;
	localparam int BIT_RATE_MIN_KBPS = 4;
	localparam int BIT_RATE_MAX_KBPS = 100;
	localparam int BIT_TOL_PCT = 11;
	// Shortest and longest accepted half cell, in clock cycles (least rounds up, longest down).
	localparam int HALF_MIN_CYC = (CLK_KHZ * (100 - BIT_TOL_PCT) + 2 * BIT_RATE_MAX_KBPS * 100 - 1)
		/ (2 * BIT_RATE_MAX_KBPS * 100);
	localparam int HALF_MAX_CYC = (CLK_KHZ * (100 + BIT_TOL_PCT)) / (2 * BIT_RATE_MIN_KBPS * 100);
	// Least wait from the end of a write frame to the programming pulse.
	localparam int PROG_SETUP_US = 40;
	localparam int PROG_SETUP_CYC = (PROG_SETUP_US * CLK_KHZ + 999) / 1000;
	// Decoder timing, counted in quarter bits of the measured cell (one quarter is half a half cell).
	localparam int MID_OPEN_QTR = 3;
	localparam int MID_LATE_QTR = 5;
	localparam int RESP_GAP_QTR = 4;
	// Frame layout.
	localparam int SYNC_BITS = 2;
	localparam int READ_FRAME_BITS = 16;
	localparam int WRITE_FRAME_BITS = 32;
	localparam int BODY_BITS = WRITE_FRAME_BITS - SYNC_BITS;
	localparam int CS_W = 4;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 16;
	localparam int CRC_W = 3;
	localparam logic [2:0] CRC_SEED = 3'h7;
	localparam logic RW_WRITE = 1'b0;
	localparam logic RW_READ = 1'b1;
	// Bit positions inside the collected body, counted from the last bit received.
	localparam int RD_RW_POS = 13;
	localparam int RD_CS_LSB = 9;
	localparam int RD_ADDR_LSB = 3;
	localparam int WR_RW_POS = 29;
	localparam int WR_CS_LSB = 25;
	localparam int WR_ADDR_LSB = 19;
	localparam int WR_DATA_LSB = 3;

	// One decoded command.
	typedef struct packed {
		logic write;
		logic [CS_W-1:0] chip_sel;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} mcr_cmd_t;

	// Die identity as seen by the receiver.
	typedef struct packed {
		logic broadcast;
		logic [1:0] die_id;
	} mcr_ident_t;
endpackage : mcr_pkg

// File: src/mcr_frame_receiver.sv
// Manchester command frame receiver for the supply-line programming link.
`timescale 1ns/1ps

// What this block does, and what it expects of the controller
// [R1] Mid-cell falling edge decodes as one, rising edge as zero.
// [R2] A frame opens with two zero sync bits; otherwise it is dropped.
// [R3] Bit after sync: zero means write, one means read.
// [R4] Four chip select bits follow the read/write bit.
// [R5] Six address bits follow, then sixteen data bits in write frames only.
// [R6] Three trailing CRC bits; a mismatch flags an error and drops the frame.
// [R7] With interface select low, identifier is high strap, low strap.
// [R8] Die is selected when its identifier's chip select bit is set.
// [R9] Zero chip select or interface select high means broadcast, no comparison.
// [R10] Bit timing is measured from each frame, 4 to 100 kbps.
// [R11] Controller keeps bit period within plus or minus eleven percent.
// [R12] Read response starts a quarter to three quarters bit after the frame.
// [R13] Controller waits 40 us after a write before the programming pulse.
// [R14] Controller lets supply fall below 6.0 V before the next frame.
// [R15] Controller reads one die at a time on a shared output line.
// [R16] CRC x^3+x+1, seed 111, sync bits excluded.
// [R17] Address and data arrive most significant bit first.
// [R18] Serial disable bit set means all line activity is ignored; here it only blocks a new frame from opening.
// [R19] A frame not broadcast and not selecting this die causes no action.
module mcr_frame_receiver #(
	parameter int CNT_W = 14
) (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic line_in,
	input wire logic id_strap_low_in,
	input wire logic id_strap_high_in,
	input wire logic interface_select_pin_in,
	input wire logic serial_disable_bit_in,
	output mcr_pkg::mcr_cmd_t cmd_out,
	output mcr_pkg::mcr_ident_t ident_out,
	output logic write_valid_out,
	output logic read_start_out,
	output logic crc_error_out,
	output logic abort_error_out,
	output logic prog_setup_ok_out
);
	import mcr_pkg::*;

	// The counter must hold more than three of the longest half cell.
	if ((2 ** CNT_W) <= 3 * HALF_MAX_CYC) begin : g_cnt_w_check
		$error("CNT_W too small for the slowest bit rate");
	end

	localparam int SETUP_W = $clog2(PROG_SETUP_CYC + 1);

	typedef enum logic [1:0] {ST_IDLE, ST_MEAS, ST_BITS, ST_GAP} mcr_state_t;

	// One CRC step; the feedback taps follow x^3 + x + 1.
	function automatic logic [2:0] crc_step(input logic [2:0] c, input logic b);
		logic fb;
		fb = b ^ c[2];
		return {c[1], c[0] ^ fb, fb};
	endfunction : crc_step

	// Scale a half-cell count by a number of quarter cells.
	function automatic logic [CNT_W-1:0] quarters(input logic [CNT_W-1:0] h, input int n);
		logic [CNT_W+2:0] w;
		w = ({3'h0, h} * (CNT_W+3)'(n)) >> 1;
		return w[CNT_W-1:0];
	endfunction : quarters

	mcr_state_t state_q, state_d;
	logic line_q;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [CNT_W-1:0] half_q, half_d;
	logic [4:0] bitnum_q, bitnum_d;
	logic rw_q, rw_d;
	logic [BODY_BITS-1:0] body_q, body_d;
	logic [2:0] crc_q, crc_d;
	logic [CNT_W-1:0] gap_q, gap_d;
	logic gap_read_q, gap_read_d;
	logic gap_write_q, gap_write_d;
	mcr_cmd_t cmd_q, cmd_d;
	mcr_ident_t ident_q;
	logic wr_q, wr_d, rd_q, rd_d, crc_err_q, crc_err_d, abort_q, abort_d;
	logic [SETUP_W-1:0] setup_q, setup_d;
	logic setup_ok_q, setup_ok_d;

	// Edge detection and the mid-cell window around the expected transition.
	wire logic edge_seen = line_in != line_q;
	wire logic in_window = cnt_q >= quarters(half_q, MID_OPEN_QTR); // see [R11]
	wire logic timed_out = cnt_q > quarters(half_q, MID_LATE_QTR); // see [R11]
	wire logic mid_edge = edge_seen && in_window;
	wire logic bit_val = line_q; // see [R1]
	wire logic rw_now = (bitnum_q == 5'd2) ? bit_val : rw_q; // see [R3]
	wire logic [4:0] frame_last = (rw_now == RW_READ) ? 5'(READ_FRAME_BITS - 1)
		: 5'(WRITE_FRAME_BITS - 1);
	wire logic in_crc_field = bitnum_q > frame_last - 5'(CRC_W);
	wire logic [BODY_BITS-1:0] body_next = {body_q[BODY_BITS-2:0], bit_val}; // see [R17]

	// Field extraction from the completed body of a read or a write frame.
	wire logic is_read = rw_now == RW_READ;
	wire logic [CS_W-1:0] f_cs = is_read ? body_next[RD_CS_LSB +: CS_W]
		: body_next[WR_CS_LSB +: CS_W]; // see [R4]
	wire logic [ADDR_W-1:0] f_addr = is_read ? body_next[RD_ADDR_LSB +: ADDR_W]
		: body_next[WR_ADDR_LSB +: ADDR_W]; // see [R5]
	wire logic [DATA_W-1:0] f_data = is_read ? '0 : body_next[WR_DATA_LSB +: DATA_W]; // see [R5]
	wire logic crc_ok = body_next[CRC_W-1:0] == crc_q; // see [R6]

	// Identity: strap pair in one mode, forced broadcast in the other.
	wire logic [1:0] die_id = {id_strap_high_in, id_strap_low_in}; // see [R7]
	wire logic is_bcast = (f_cs == '0) || interface_select_pin_in; // see [R9]
	wire logic is_sel = is_bcast || f_cs[die_id]; // see [R8]

	// Decoder state machine; the first half cell is checked against fixed limits, later timing is relative to the measured half cell.
	always_comb begin
		state_d = state_q;
		cnt_d = (cnt_q == '1) ? cnt_q : cnt_q + 1'b1;
		half_d = half_q;
		bitnum_d = bitnum_q;
		rw_d = rw_q;
		body_d = body_q;
		crc_d = crc_q;
		gap_d = gap_q;
		gap_read_d = gap_read_q;
		gap_write_d = gap_write_q;
		cmd_d = cmd_q;
		wr_d = 1'b0;
		rd_d = 1'b0;
		crc_err_d = 1'b0;
		abort_d = 1'b0;
		case (state_q)
			ST_IDLE: begin
				// A falling edge opens the first sync cell.
				if (edge_seen && line_q && !serial_disable_bit_in) begin // see [R18]
					state_d = ST_MEAS;
					cnt_d = '0;
				end
			end
			ST_MEAS: begin
				// First sync bit: the rising edge gives the half cell length.
				if (edge_seen) begin
					if (cnt_q + 1'b1 >= CNT_W'(HALF_MIN_CYC) && cnt_q < CNT_W'(HALF_MAX_CYC)) begin
						state_d = ST_BITS; // see [R10]
						half_d = cnt_q + 1'b1;
						cnt_d = '0;
						bitnum_d = 5'd1;
						crc_d = CRC_SEED; // see [R16]
						body_d = '0;
					end else begin
						state_d = ST_IDLE;
						abort_d = 1'b1;
					end
				end else if (cnt_q >= CNT_W'(HALF_MAX_CYC)) begin
					state_d = ST_IDLE;
					abort_d = 1'b1;
				end
			end
			ST_BITS: begin
				if (mid_edge) begin
					cnt_d = '0;
					bitnum_d = bitnum_q + 1'b1;
					if (bitnum_q == 5'(SYNC_BITS - 1)) begin
						// Second sync bit must be zero.
						if (bit_val) begin // see [R2]
							state_d = ST_IDLE;
							abort_d = 1'b1;
						end
					end else begin
						body_d = body_next;
						rw_d = rw_now;
						if (!in_crc_field) begin
							crc_d = crc_step(crc_q, bit_val); // see [R16]
						end
						if (bitnum_q == frame_last) begin
							state_d = ST_GAP;
							gap_read_d = is_read;
							gap_write_d = !is_read;
							// Two half cells past the last mid edge is half a bit past the trailing edge.
							gap_d = quarters(half_q, RESP_GAP_QTR); // see [R12]
							crc_err_d = !crc_ok; // see [R6]
							if (crc_ok && is_sel) begin // see [R19]
								cmd_d = '{write: !is_read, chip_sel: f_cs, addr: f_addr, data: f_data};
								wr_d = !is_read;
							end else begin
								gap_read_d = 1'b0;
								gap_write_d = 1'b0;
							end
						end
					end
				end else if (timed_out) begin
					state_d = ST_IDLE;
					abort_d = 1'b1;
				end
			end
			ST_GAP: begin
				// Wait out the rest of the last cell plus the response delay.
				if (cnt_q + 1'b1 >= gap_q) begin
					state_d = ST_IDLE;
					rd_d = gap_read_q; // see [R12]
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// Programming setup window: opens once the write frame has ended long enough.
	// Keyed to this frame's own acceptance, so a rejected write never reuses an older command.
	wire logic write_end = (state_q == ST_GAP) && (state_d == ST_IDLE) && gap_write_q;
	always_comb begin
		setup_d = setup_q;
		setup_ok_d = setup_ok_q;
		if (state_d == ST_MEAS) begin
			setup_ok_d = 1'b0;
			setup_d = '0;
		end else if (write_end && !crc_err_q) begin
			setup_d = SETUP_W'(PROG_SETUP_CYC); // see [R13]
			setup_ok_d = 1'b0;
		end else if (setup_q != '0) begin
			setup_d = setup_q - 1'b1;
			setup_ok_d = setup_q == SETUP_W'(1);
		end
	end

	// State and data registers; a synchronous reset returns to idle.
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			state_q <= ST_IDLE;
			line_q <= 1'b1;
			cnt_q <= '0;
			half_q <= '0;
			bitnum_q <= '0;
			rw_q <= 1'b0;
			body_q <= '0;
			crc_q <= CRC_SEED;
			gap_q <= '0;
			gap_read_q <= 1'b0;
			gap_write_q <= 1'b0;
			cmd_q <= '0;
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			crc_err_q <= 1'b0;
			abort_q <= 1'b0;
			setup_q <= '0;
			setup_ok_q <= 1'b0;
		end else begin
			state_q <= state_d;
			line_q <= line_in;
			cnt_q <= cnt_d;
			half_q <= half_d;
			bitnum_q <= bitnum_d;
			rw_q <= rw_d;
			body_q <= body_d;
			crc_q <= crc_d;
			gap_q <= gap_d;
			gap_read_q <= gap_read_d;
			gap_write_q <= gap_write_d;
			cmd_q <= cmd_d;
			wr_q <= wr_d;
			rd_q <= rd_d;
			crc_err_q <= crc_err_d;
			abort_q <= abort_d;
			setup_q <= setup_d;
			setup_ok_q <= setup_ok_d;
		end
	end

	// Identity is registered, so the reported value follows the strap state one cycle later.
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			ident_q <= '0;
		end else begin
			ident_q <= '{broadcast: interface_select_pin_in, die_id: die_id};
		end
	end

	assign cmd_out = cmd_q;
	assign ident_out = ident_q;
	assign write_valid_out = wr_q;
	assign read_start_out = rd_q;
	assign crc_error_out = crc_err_q;
	assign abort_error_out = abort_q;
	assign prog_setup_ok_out = setup_ok_q;
endmodule : mcr_frame_receiver

// File: verification/mcr_ctrl_model.sv
// Behavioural programming controller that drives command frames onto the supply line.
`timescale 1ns/1ps
module mcr_ctrl_model (
	input wire logic ref_clk_in,
	output logic line_out
);
	// The line rests high between frames.
	initial line_out = 1'b1;
	// Send n bits MSB first, each cell two half cells of h clocks; h stays fixed.
	task automatic send(input logic [31:0] bits, input int n, input int h);
		for (int i = n - 1; i >= 0; i--) begin
			@(posedge ref_clk_in) line_out <= bits[i];
			repeat (h) @(posedge ref_clk_in);
			line_out <= ~bits[i];
			repeat (h - 1) @(posedge ref_clk_in);
		end
		@(posedge ref_clk_in) line_out <= 1'b1;
	endtask : send
endmodule : mcr_ctrl_model

// File: verification/mcr_frame_receiver_assertions.sv
// Concurrent checks on the frame receiver ports.
`timescale 1ns/1ps
module mcr_frame_receiver_checker
	import mcr_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic interface_select_pin_in,
	input wire logic id_strap_low_in,
	input wire logic id_strap_high_in,
	input mcr_pkg::mcr_cmd_t cmd_out,
	input mcr_pkg::mcr_ident_t ident_out,
	input wire logic write_valid_out,
	input wire logic read_start_out,
	input wire logic crc_error_out,
	input wire logic abort_error_out,
	input wire logic prog_setup_ok_out
);
	// Every check shares the one clock and is quiet while reset is held.
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	property p_wv_pulse; write_valid_out |=> !write_valid_out; endproperty
	a_wv_pulse: assert property (p_wv_pulse) else $error("write strobe too long");
	property p_rs_pulse; read_start_out |=> !read_start_out; endproperty
	a_rs_pulse: assert property (p_rs_pulse) else $error("read strobe too long");
	property p_crc; crc_error_out |-> !write_valid_out && !read_start_out; endproperty
	a_crc: assert property (p_crc) else $error("bad frame was acted on");
	property p_ab; abort_error_out |-> !write_valid_out && !crc_error_out; endproperty
	a_ab: assert property (p_ab) else $error("aborted frame was acted on");
	property p_rs_cmd; read_start_out |-> !cmd_out.write && cmd_out.data == 16'h0; endproperty
	a_rs_cmd: assert property (p_rs_cmd) else $error("read command fields wrong");
	property p_wv_cmd; write_valid_out |-> cmd_out.write; endproperty
	a_wv_cmd: assert property (p_wv_cmd) else $error("write command not shown");
	property p_ident;
		!$past(rst_in) && !$past(interface_select_pin_in) |->
			ident_out.die_id == {$past(id_strap_high_in), $past(id_strap_low_in)};
	endproperty
	a_ident: assert property (p_ident) else $error("identifier does not follow straps");
	property p_bcast; !$past(rst_in) |-> ident_out.broadcast == $past(interface_select_pin_in);
	endproperty
	a_bcast: assert property (p_bcast) else $error("broadcast flag wrong");
	property p_prog; write_valid_out |=> !prog_setup_ok_out [*8]; endproperty
	a_prog: assert property (p_prog) else $error("setup flag early after write");
	c_write: cover property (write_valid_out);
	c_read: cover property (read_start_out);
	c_crc: cover property (crc_error_out);
	c_abort: cover property (abort_error_out);
endmodule : mcr_frame_receiver_checker
bind mcr_frame_receiver mcr_frame_receiver_checker u_chk (.ref_clk_in(ref_clk_in),
	.rst_in(rst_in), .interface_select_pin_in(interface_select_pin_in),
	.id_strap_low_in(id_strap_low_in), .id_strap_high_in(id_strap_high_in),
	.cmd_out(cmd_out), .ident_out(ident_out), .write_valid_out(write_valid_out),
	.read_start_out(read_start_out), .crc_error_out(crc_error_out),
	.abort_error_out(abort_error_out), .prog_setup_ok_out(prog_setup_ok_out));

// File: verification/testbench.sv
// Self-checking bench for the supply-line command frame receiver.
`timescale 1ns/1ps
module testbench;
	import mcr_pkg::*;
	logic ref_clk_in, rst_in, line_in, lo, hi, interface_select_pin, dis, prog;
	wire [3:0] pls;
	mcr_cmd_t cmd;
	mcr_ident_t ident;
	int n_errors = 0, comparisons = 0, cyc = 0, t_end = 0, rs_cyc = 0;
	int tot[4] = '{0, 0, 0, 0};
	mcr_ctrl_model ctrl (.ref_clk_in(ref_clk_in), .line_out(line_in));
	mcr_frame_receiver DUT (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .line_in(line_in),
		.id_strap_low_in(lo), .id_strap_high_in(hi), .interface_select_pin_in(interface_select_pin),
		.serial_disable_bit_in(dis), .cmd_out(cmd), .ident_out(ident),
		.write_valid_out(pls[0]), .read_start_out(pls[1]), .crc_error_out(pls[2]),
		.abort_error_out(pls[3]), .prog_setup_ok_out(prog));
	// Clock at 20 MHz.
	initial begin
		ref_clk_in = 1'b0;
		forever #25 ref_clk_in = ~ref_clk_in;
	end
	// Pulse tallies, plus a ceiling so that a hang still reaches the verdict.
	always @(posedge ref_clk_in) begin
		cyc <= cyc + 1;
		for (int k = 0; k < 4; k++)
			if (pls[k] === 1'b1) tot[k] <= tot[k] + 1;
		if (pls[1] === 1'b1) rs_cyc <= cyc;
		if (cyc == 90000) begin
			n_errors++;
			test_done();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk
	task automatic test_done();
		$display("comparisons %0d, mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done
	// Build a frame: two zero sync bits, body, CRC over the body only; flip spoils the CRC.
	function automatic logic [31:0] frame(input logic rd, input logic [3:0] cs,
		input logic [5:0] a, input logic [15:0] d, input logic [2:0] flip);
		logic [26:0] b;
		logic [2:0] c;
		logic fb;
		b = rd ? {16'h0, rd, cs, a} : {rd, cs, a, d};
		c = CRC_SEED;
		for (int i = (rd ? 10 : 26); i >= 0; i--) begin
			fb = b[i] ^ c[2];
			c = {c[1], c[0] ^ fb, fb};
		end
		return {2'h0, b, c ^ flip};
	endfunction : frame
	// Send one frame, let the answer land, then compare the pulse counts {abort,crc,read,write}.
	task automatic run(input logic [31:0] f, input int n, input int h, input logic [3:0] exp);
		int s[4];
		s = tot;
		ctrl.send(f, n, h);
		t_end = cyc;
		repeat (3 * h + 20) @(posedge ref_clk_in);
		for (int k = 0; k < 4; k++)
			chk(tot[k] - s[k], exp[k]);
		$display("test done at %0t", $time);
	endtask : run
	// Main sequence; the controller waits out the setup time after each write.
	initial begin
		{rst_in, lo, hi, interface_select_pin, dis} = 5'h10;
		repeat (12) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			{hi, lo} <= k[1:0];
			repeat (3) @(posedge ref_clk_in);
			chk(ident, {1'b0, k[1:0]});
		end
		{hi, lo} <= 2'h2;
		run(frame(1'b0, 4'h0, 6'h2A, 16'hA5C3, 3'h0), 32, 100, 4'h1);
		chk(cmd, {1'b1, 4'h0, 6'h2A, 16'hA5C3});
		chk(prog, 1'b0);
		repeat (600) @(posedge ref_clk_in);
		chk(prog, 1'b1);
		// A rejected write must neither replace the command nor reopen the setup window.
		run(frame(1'b0, 4'h4, 6'h01, 16'h8001, 3'h1), 32, 100, 4'h4);
		chk(cmd, {1'b1, 4'h0, 6'h2A, 16'hA5C3});
		repeat (600) @(posedge ref_clk_in);
		chk(prog, 1'b0);
		run(frame(1'b1, 4'h4, 6'h15, 16'h0, 3'h0), 16, 500, 4'h2);
		chk(cmd, {1'b0, 4'h4, 6'h15, 16'h0});
		chk(rs_cyc - t_end >= 250 && rs_cyc - t_end <= 750, 1'b1);
		for (int k = 0; k < 4; k++)
			run(frame(1'b1, 4'h1 << k, 6'h3, 16'h0, 3'h0), 16, 100, 4'(k == 2) << 1);
		run(32'h1, 2, 100, 4'h8);
		dis <= 1'b1;
		run(frame(1'b1, 4'h4, 6'h15, 16'h0, 3'h0), 16, 100, 4'h0);
		{dis, interface_select_pin} <= 2'h1;
		run(frame(1'b1, 4'h1, 6'h15, 16'h0, 3'h0), 16, 100, 4'h2);
		chk(ident.broadcast, 1'b1);
		test_done();
	end
endmodule : testbench
